// File: pma_pkg.sv
package pma_pkg;

  // ----------------------------------------------------------------
  // datapath geometry
  // ----------------------------------------------------------------
  localparam int NODES = 8;
  localparam int STREAMS = 4;
  localparam int METERS = 3;
  localparam int SW = 18;
  localparam int PW = 32;
  localparam int PWR_SHIFT = 4;
  localparam int FRAC = 16;
  localparam int AW = PW + FRAC;
  localparam int SUMW = 48;
  localparam int CNTW = 16;
  localparam int GW = 16;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_MTR_STAT = 8'h00;
  localparam logic [7:0] A_ALM_STAT = 8'h04;
  localparam logic [7:0] A_RA_CFG = 8'h08;
  localparam logic [7:0] A_GATE_LEN = 8'h0c;
  localparam logic [7:0] A_PK_WIN = 8'h10;
  localparam logic [7:0] A_PK_SAMP = 8'h14;
  localparam logic [7:0] A_MTR_BASE = 8'h20;
  localparam logic [7:0] A_MTR_STRIDE = 8'h20;
  localparam logic [7:0] A_STRM_BASE = 8'h80;
  localparam logic [7:0] A_STRM_STRIDE = 8'h10;
  localparam logic [7:0] A_Y_BASE = 8'hc0;
  localparam logic [7:0] A_PKC_BASE = 8'hd0;
  // word offsets inside one interval meter block
  localparam logic [2:0] M_CFG = 3'h0;
  localparam logic [2:0] M_LEN = 3'h1;
  localparam logic [2:0] M_THR1 = 3'h2;
  localparam logic [2:0] M_THR2 = 3'h3;
  localparam logic [2:0] M_SUM_LO = 3'h4;
  localparam logic [2:0] M_SUM_HI = 3'h5;
  localparam logic [2:0] M_PEAK = 3'h6;
  localparam logic [2:0] M_CNTS = 3'h7;
  // word offsets inside one stream block
  localparam logic [1:0] S_HI = 2'h0;
  localparam logic [1:0] S_LO = 2'h1;
  localparam logic [1:0] S_PKTHR = 2'h2;
  localparam logic [1:0] S_GAIN = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // interval meter cfg: node[2:0] stream[4:3] en[5] sync_src[6] rerun[7] start[8]
  localparam int MC_NODE = 0;
  localparam int MC_STRM = 3;
  localparam int MC_EN = 5;
  localparam int MC_SSRC = 6;
  localparam int MC_RERUN = 7;
  localparam int MC_START = 8;
  localparam int MC_W = 8;
  // running-average cfg
  localparam int RC_NODE = 0;
  localparam int RC_U = 3;
  localparam int RC_GATE_EN = 7;
  localparam int RC_GATE_SRC = 8;
  localparam int RC_MODE0 = 9;
  localparam int RC_MODE1 = 11;
  localparam int RC_POL0 = 13;
  localparam int RC_POL1 = 15;
  localparam int RC_ACT1 = 17;
  localparam int RC_EN = 18;
  localparam int RC_W = 19;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [RC_W-1:0] RA_CFG_RST = 19'h00058;
  localparam logic [PW-1:0] LEN_RST = 32'h00000400;
  localparam logic [PW-1:0] PK_WIN_RST = 32'h00000100;
  localparam logic [GW-1:0] GAIN_RST = 16'h8000;
  localparam logic [3:0] U_MIN = 4'h1;
  localparam logic [3:0] U_MAX = 4'he;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AVG = 2'h1;
  localparam logic [1:0] MODE_PEAK = 2'h2;
  localparam logic [1:0] MODE_ANY = 2'h3;
  localparam logic [1:0] POL_HIGH = 2'h0;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_BOTH = 2'h2;

endpackage

// File: pma_top.sv
`timescale 1ns/1ps
module pma_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // sample nodes, flattened node-major then stream
  input wire logic [pma_pkg::NODES*pma_pkg::STREAMS*pma_pkg::SW-1:0] node_i,
  input wire logic [pma_pkg::NODES*pma_pkg::STREAMS*pma_pkg::SW-1:0] node_q,
  input wire logic [pma_pkg::NODES-1:0] node_valid,
  // syncs
  input wire logic startup_trigger_in,
  input wire logic shared_feedback_trigger_in,
  output logic event_trigger_out,
  // alarms and gain control
  output logic irq_out_pin,
  output logic [pma_pkg::STREAMS-1:0] cfr_gain_sel,
  output logic [pma_pkg::STREAMS*pma_pkg::GW-1:0] cfr_gain_value
);

  // ----------------------------------------------------------------
  // sync inputs
  // ----------------------------------------------------------------
  logic [1:0] sync_s1_ff;
  logic [1:0] sync_s2_ff;
  logic [1:0] sync_s3_ff;
  wire [1:0] sync_rise = sync_s2_ff & ~sync_s3_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_s1_ff <= 2'h0;
      sync_s2_ff <= 2'h0;
      sync_s3_ff <= 2'h0;
    end else begin
      sync_s1_ff <= {shared_feedback_trigger_in, startup_trigger_in};
      sync_s2_ff <= sync_s1_ff;
      sync_s3_ff <= sync_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_mstat = reg_wr && reg_addr == pma_pkg::A_MTR_STAT;
  wire wr_astat = reg_wr && reg_addr == pma_pkg::A_ALM_STAT;
  wire wr_racfg = reg_wr && reg_addr == pma_pkg::A_RA_CFG;
  wire wr_gate = reg_wr && reg_addr == pma_pkg::A_GATE_LEN;
  wire wr_pkwin = reg_wr && reg_addr == pma_pkg::A_PK_WIN;
  wire wr_pksamp = reg_wr && reg_addr == pma_pkg::A_PK_SAMP;

  logic [pma_pkg::RC_W-1:0] ra_cfg_ff;
  logic [31:0] gate_len_ff;
  logic [31:0] pk_win_ff;
  logic [31:0] pk_samp_ff;
  logic [pma_pkg::METERS-1:0] mtr_new_ff;
  logic [2*pma_pkg::STREAMS-1:0] alm_ff;
  logic [31:0] rd_word [64];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ra_cfg_ff <= pma_pkg::RA_CFG_RST;
      gate_len_ff <= 32'h0;
      pk_win_ff <= pma_pkg::PK_WIN_RST;
      pk_samp_ff <= 32'h0;
    end else begin
      if (wr_racfg) ra_cfg_ff <= reg_wdata[pma_pkg::RC_W-1:0];
      if (wr_gate) gate_len_ff <= reg_wdata;
      if (wr_pkwin) pk_win_ff <= reg_wdata;
      if (wr_pksamp) pk_samp_ff <= reg_wdata;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) reg_rdata <= 32'h0;
    else if (reg_rd) reg_rdata <= rd_word[reg_addr[7:2]];
    else reg_rdata <= 32'h0;
  end

  // ----------------------------------------------------------------
  // running-average configuration fields
  // ----------------------------------------------------------------
  wire [2:0] ra_node = ra_cfg_ff[pma_pkg::RC_NODE +: 3];
  wire [3:0] u_raw = ra_cfg_ff[pma_pkg::RC_U +: 4];
  // out-of-range exponents are clamped so the average never freezes or jumps
  wire [3:0] u_eff = (u_raw < pma_pkg::U_MIN) ? pma_pkg::U_MIN :
                     (u_raw > pma_pkg::U_MAX) ? pma_pkg::U_MAX : u_raw;
  wire [1:0] mode0 = ra_cfg_ff[pma_pkg::RC_MODE0 +: 2];
  wire [1:0] mode1 = ra_cfg_ff[pma_pkg::RC_MODE1 +: 2];
  wire [1:0] pol0 = ra_cfg_ff[pma_pkg::RC_POL0 +: 2];
  wire [1:0] pol1 = ra_cfg_ff[pma_pkg::RC_POL1 +: 2];
  wire act1 = ra_cfg_ff[pma_pkg::RC_ACT1];
  wire ra_en = ra_cfg_ff[pma_pkg::RC_EN];
  wire gate_src_hit = sync_rise[ra_cfg_ff[pma_pkg::RC_GATE_SRC]];

  // ----------------------------------------------------------------
  // gating window
  // ----------------------------------------------------------------
  logic [31:0] gate_cnt_ff;
  wire gate_open = !ra_cfg_ff[pma_pkg::RC_GATE_EN] || gate_cnt_ff != 32'h0;
  wire ra_step = ra_en && gate_open && node_valid[ra_node];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) gate_cnt_ff <= 32'h0;
    else if (gate_src_hit) gate_cnt_ff <= gate_len_ff;
    else if (gate_cnt_ff != 32'h0) gate_cnt_ff <= gate_cnt_ff - 32'h1;
  end

  // ----------------------------------------------------------------
  // shared peak window counter
  // ----------------------------------------------------------------
  logic [31:0] win_cnt_ff;
  wire win_end = ra_step && (win_cnt_ff + 32'h1 >= pk_win_ff);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) win_cnt_ff <= 32'h0;
    else if (!ra_en) win_cnt_ff <= 32'h0;
    else if (win_end) win_cnt_ff <= 32'h0;
    else if (ra_step) win_cnt_ff <= win_cnt_ff + 32'h1;
  end

  // ----------------------------------------------------------------
  // per-stream running average, peaks and alarms
  // ----------------------------------------------------------------
  logic [pma_pkg::STREAMS-1:0] alm0_hit;
  logic [pma_pkg::STREAMS-1:0] alm1_hit;
  logic [pma_pkg::STREAMS-1:0] alm1_hi_cause;

  genvar s;
  generate
    for (s = 0; s < pma_pkg::STREAMS; s++) begin : g_strm
      localparam logic [7:0] SBASE = pma_pkg::A_STRM_BASE + 8'(s) * pma_pkg::A_STRM_STRIDE;
      logic [31:0] hi_thr_ff;
      logic [31:0] lo_thr_ff;
      logic [31:0] pk_thr_ff;
      logic [pma_pkg::GW-1:0] gain_ff;
      logic [pma_pkg::AW-1:0] y_acc_ff;
      logic [31:0] pk_cnt_ff;
      logic cond0_ff;
      logic cond1_ff;
      logic gsel_ff;
      wire [4:0] lane = {ra_node, 2'(s)};
      wire signed [pma_pkg::SW-1:0] xi = node_i[lane*pma_pkg::SW +: pma_pkg::SW];
      wire signed [pma_pkg::SW-1:0] xq = node_q[lane*pma_pkg::SW +: pma_pkg::SW];
      wire signed [2*pma_pkg::SW-1:0] ii = xi * xi;
      wire signed [2*pma_pkg::SW-1:0] qq = xq * xq;
      wire [2*pma_pkg::SW:0] mag = {1'b0, ii} + {1'b0, qq};
      wire [pma_pkg::PW-1:0] pwr = mag[pma_pkg::PWR_SHIFT +: pma_pkg::PW];
      wire [pma_pkg::AW-1:0] pwr_fx = {pwr, {pma_pkg::FRAC{1'b0}}};
      // rewritten as y - y*2^-u + p*2^-u so the sum never goes negative
      wire [pma_pkg::AW-1:0] nxt_y_acc =
        y_acc_ff - (y_acc_ff >> u_eff) + (pwr_fx >> u_eff);
      wire [31:0] y = y_acc_ff[pma_pkg::FRAC +: pma_pkg::PW];
      wire is_peak = pwr > pk_thr_ff;
      wire above = y > hi_thr_ff;
      wire below = y < lo_thr_ff;
      wire pk_cond = pk_cnt_ff > pk_samp_ff;
      wire avg0 = (pol0 == pma_pkg::POL_HIGH && above) || (pol0 == pma_pkg::POL_LOW && below) ||
                  (pol0 == pma_pkg::POL_BOTH && (above || below));
      wire hi1 = (pol1 == pma_pkg::POL_HIGH || pol1 == pma_pkg::POL_BOTH) && above;
      wire avg1 = hi1 || (pol1 == pma_pkg::POL_LOW && below) ||
                  (pol1 == pma_pkg::POL_BOTH && below);
      wire cond0 = (mode0 == pma_pkg::MODE_AVG && avg0) || (mode0 == pma_pkg::MODE_PEAK && pk_cond) ||
                   (mode0 == pma_pkg::MODE_ANY && (avg0 || pk_cond));
      wire cond1 = (mode1 == pma_pkg::MODE_AVG && avg1) || (mode1 == pma_pkg::MODE_PEAK && pk_cond) ||
                   (mode1 == pma_pkg::MODE_ANY && (avg1 || pk_cond));
      wire hi_path = hi1 && (mode1 == pma_pkg::MODE_AVG || mode1 == pma_pkg::MODE_ANY);
      wire gsel_clr = wr_astat && reg_wdata[pma_pkg::STREAMS + s];

      assign alm0_hit[s] = cond0 && !cond0_ff;
      assign alm1_hit[s] = cond1 && !cond1_ff;
      assign alm1_hi_cause[s] = alm1_hit[s] && hi_path;

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          hi_thr_ff <= 32'hffffffff;
          lo_thr_ff <= 32'h0;
          pk_thr_ff <= 32'hffffffff;
          gain_ff <= pma_pkg::GAIN_RST;
        end else if (reg_wr && reg_addr[7:4] == SBASE[7:4]) begin
          if (reg_addr[3:2] == pma_pkg::S_HI) hi_thr_ff <= reg_wdata;
          if (reg_addr[3:2] == pma_pkg::S_LO) lo_thr_ff <= reg_wdata;
          if (reg_addr[3:2] == pma_pkg::S_PKTHR) pk_thr_ff <= reg_wdata;
          if (reg_addr[3:2] == pma_pkg::S_GAIN) gain_ff <= reg_wdata[pma_pkg::GW-1:0];
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          y_acc_ff <= '0;
          pk_cnt_ff <= 32'h0;
          cond0_ff <= 1'b0;
          cond1_ff <= 1'b0;
        end else begin
          if (ra_step) y_acc_ff <= nxt_y_acc;
          if (!ra_en || win_end) pk_cnt_ff <= 32'h0;
          else if (ra_step && is_peak) pk_cnt_ff <= pk_cnt_ff + 32'h1;
          cond0_ff <= cond0;
          cond1_ff <= cond1;
        end
      end

      // set wins over the host clear
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) gsel_ff <= 1'b0;
        else if (alm1_hi_cause[s] && act1) gsel_ff <= 1'b1;
        else if (gsel_clr) gsel_ff <= 1'b0;
      end

      assign cfr_gain_sel[s] = gsel_ff;
      assign cfr_gain_value[s*pma_pkg::GW +: pma_pkg::GW] = gain_ff;
      assign rd_word[SBASE[7:2] + 6'(pma_pkg::S_HI)] = hi_thr_ff;
      assign rd_word[SBASE[7:2] + 6'(pma_pkg::S_LO)] = lo_thr_ff;
      assign rd_word[SBASE[7:2] + 6'(pma_pkg::S_PKTHR)] = pk_thr_ff;
      assign rd_word[SBASE[7:2] + 6'(pma_pkg::S_GAIN)] = {16'h0, gain_ff};
      assign rd_word[pma_pkg::A_Y_BASE[7:2] + 6'(s)] = y;
      assign rd_word[pma_pkg::A_PKC_BASE[7:2] + 6'(s)] = pk_cnt_ff;
    end
  endgenerate

  // ----------------------------------------------------------------
  // alarm status and interrupt pin
  // ----------------------------------------------------------------
  wire [2*pma_pkg::STREAMS-1:0] alm_set = {alm1_hit, alm0_hit};
  wire [2*pma_pkg::STREAMS-1:0] alm_clr = wr_astat ? reg_wdata[2*pma_pkg::STREAMS-1:0] : '0;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) alm_ff <= '0;
    else alm_ff <= (alm_ff & ~alm_clr) | alm_set;
  end

  assign irq_out_pin = |alm_ff;

  // ----------------------------------------------------------------
  // interval meters
  // ----------------------------------------------------------------
  logic [pma_pkg::METERS-1:0] mtr_done;

  genvar m;
  generate
    for (m = 0; m < pma_pkg::METERS; m++) begin : g_mtr
      localparam logic [7:0] MBASE = pma_pkg::A_MTR_BASE + 8'(m) * pma_pkg::A_MTR_STRIDE;
      logic [pma_pkg::MC_W-1:0] cfg_ff;
      logic [31:0] len_ff;
      logic [31:0] thr1_ff;
      logic [31:0] thr2_ff;
      logic run_ff;
      logic [31:0] left_ff;
      logic [pma_pkg::SUMW-1:0] sum_ff;
      logic [31:0] peak_ff;
      logic [pma_pkg::CNTW-1:0] c1_ff;
      logic [pma_pkg::CNTW-1:0] c2_ff;
      logic [pma_pkg::SUMW-1:0] r_sum_ff;
      logic [31:0] r_peak_ff;
      logic [pma_pkg::CNTW-1:0] r_c1_ff;
      logic [pma_pkg::CNTW-1:0] r_c2_ff;
      wire wr_me = reg_wr && reg_addr[7:5] == MBASE[7:5];
      wire wr_cfg = wr_me && reg_addr[4:2] == pma_pkg::M_CFG;
      wire [4:0] lane = {cfg_ff[pma_pkg::MC_NODE +: 3], cfg_ff[pma_pkg::MC_STRM +: 2]};
      wire vld = node_valid[cfg_ff[pma_pkg::MC_NODE +: 3]];
      wire signed [pma_pkg::SW-1:0] xi = node_i[lane*pma_pkg::SW +: pma_pkg::SW];
      wire signed [pma_pkg::SW-1:0] xq = node_q[lane*pma_pkg::SW +: pma_pkg::SW];
      wire signed [2*pma_pkg::SW-1:0] ii = xi * xi;
      wire signed [2*pma_pkg::SW-1:0] qq = xq * xq;
      wire [2*pma_pkg::SW:0] mag = {1'b0, ii} + {1'b0, qq};
      wire [pma_pkg::PW-1:0] pwr = mag[pma_pkg::PWR_SHIFT +: pma_pkg::PW];
      wire start = cfg_ff[pma_pkg::MC_EN] && ((wr_cfg && reg_wdata[pma_pkg::MC_START]) ||
                   sync_rise[cfg_ff[pma_pkg::MC_SSRC]]);
      wire step = run_ff && vld;
      // a zero length behaves as a one-sample interval
      wire last = step && left_ff <= 32'h1;
      wire [pma_pkg::SUMW-1:0] nxt_sum = sum_ff + pma_pkg::SUMW'(pwr);
      wire [31:0] nxt_peak = pwr > peak_ff ? pwr : peak_ff;
      wire [pma_pkg::CNTW-1:0] nxt_c1 = c1_ff + pma_pkg::CNTW'(pwr > thr1_ff && ~&c1_ff);
      wire [pma_pkg::CNTW-1:0] nxt_c2 = c2_ff + pma_pkg::CNTW'(pwr > thr2_ff && ~&c2_ff);

      assign mtr_done[m] = last;

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cfg_ff <= '0;
          len_ff <= pma_pkg::LEN_RST;
          thr1_ff <= 32'hffffffff;
          thr2_ff <= 32'hffffffff;
        end else if (wr_me) begin
          if (reg_addr[4:2] == pma_pkg::M_CFG) cfg_ff <= reg_wdata[pma_pkg::MC_W-1:0];
          if (reg_addr[4:2] == pma_pkg::M_LEN) len_ff <= reg_wdata;
          if (reg_addr[4:2] == pma_pkg::M_THR1) thr1_ff <= reg_wdata;
          if (reg_addr[4:2] == pma_pkg::M_THR2) thr2_ff <= reg_wdata;
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          run_ff <= 1'b0;
          left_ff <= 32'h0;
          sum_ff <= '0;
          peak_ff <= 32'h0;
          c1_ff <= '0;
          c2_ff <= '0;
        end else if (start || (last && cfg_ff[pma_pkg::MC_RERUN])) begin
          run_ff <= 1'b1;
          left_ff <= len_ff;
          sum_ff <= '0;
          peak_ff <= 32'h0;
          c1_ff <= '0;
          c2_ff <= '0;
        end else if (step) begin
          run_ff <= !last && cfg_ff[pma_pkg::MC_EN];
          left_ff <= left_ff - 32'h1;
          sum_ff <= nxt_sum;
          peak_ff <= nxt_peak;
          c1_ff <= nxt_c1;
          c2_ff <= nxt_c2;
        end else if (!cfg_ff[pma_pkg::MC_EN]) begin
          run_ff <= 1'b0;
        end
      end

      // results hold until the next interval closes
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          r_sum_ff <= '0;
          r_peak_ff <= 32'h0;
          r_c1_ff <= '0;
          r_c2_ff <= '0;
        end else if (last) begin
          r_sum_ff <= nxt_sum;
          r_peak_ff <= nxt_peak;
          r_c1_ff <= nxt_c1;
          r_c2_ff <= nxt_c2;
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) mtr_new_ff[m] <= 1'b0;
        else if (last) mtr_new_ff[m] <= 1'b1;
        else if (wr_mstat && reg_wdata[m]) mtr_new_ff[m] <= 1'b0;
      end

      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_CFG)] = {24'h0, cfg_ff};
      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_LEN)] = len_ff;
      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_THR1)] = thr1_ff;
      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_THR2)] = thr2_ff;
      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_SUM_LO)] = r_sum_ff[31:0];
      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_SUM_HI)] = {16'h0, r_sum_ff[47:32]};
      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_PEAK)] = r_peak_ff;
      assign rd_word[MBASE[7:2] + 6'(pma_pkg::M_CNTS)] = {r_c2_ff, r_c1_ff};
    end
  endgenerate

  // ----------------------------------------------------------------
  // sync out and remaining read words
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) event_trigger_out <= 1'b0;
    else event_trigger_out <= |mtr_done;
  end

  assign rd_word[0] = {29'h0, mtr_new_ff};
  assign rd_word[1] = {24'h0, alm_ff};
  assign rd_word[2] = {13'h0, ra_cfg_ff};
  assign rd_word[3] = gate_len_ff;
  assign rd_word[4] = pk_win_ff;
  assign rd_word[5] = pk_samp_ff;
  assign rd_word[6] = 32'h0;
  assign rd_word[7] = 32'h0;

  genvar z;
  generate
    for (z = 56; z < 64; z++) begin : g_unmapped
      assign rd_word[z] = 32'h0;
    end
  endgenerate

endmodule

// File: pma_far.sv
`timescale 1ns/1ps
module pma_far (
  // clock
  input wire logic clk_sys,
  // stimulus control
  input wire logic [4*pma_pkg::SW-1:0] amp,
  input wire logic sync_go,
  // far side
  output logic [pma_pkg::NODES*pma_pkg::STREAMS*pma_pkg::SW-1:0] node_i,
  output logic [pma_pkg::NODES*pma_pkg::STREAMS*pma_pkg::SW-1:0] node_q,
  output logic [pma_pkg::NODES-1:0] node_valid,
  output logic startup_trigger_in,
  output logic shared_feedback_trigger_in
);
  // ----------------------------------------------------------------
  // samples on every node, startup sync as four-clock pulses, feedback sync held low
  // ----------------------------------------------------------------
  logic [2:0] sync_cnt_ff = 3'h0;
  assign node_valid = 8'hff;
  assign node_i = {pma_pkg::NODES{amp}};
  assign node_q = {pma_pkg::NODES{amp}};
  assign startup_trigger_in = sync_cnt_ff != 3'h0;
  assign shared_feedback_trigger_in = 1'b0;
  always_ff @(posedge clk_sys) begin
    sync_cnt_ff <= sync_go ? 3'h4 : sync_cnt_ff - {2'h0, sync_cnt_ff != 3'h0};
  end
endmodule

// File: pma_props.sv
`timescale 1ns/1ps
module pma_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // alarm outputs
  input wire logic irq_out_pin,
  input wire logic [pma_pkg::STREAMS-1:0] cfr_gain_sel,
  input wire logic [pma_pkg::STREAMS*pma_pkg::GW-1:0] cfr_gain_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire logic alm_wr = reg_wr && reg_addr[7:2] == 6'h01;
  wire logic alm_rd = reg_rd && reg_addr[7:2] == 6'h01;
  wire logic [15:0] wd_lo = reg_wdata[15:0];
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_irq_hold: assert property (irq_out_pin && !alm_wr |=> irq_out_pin)
    else $error("interrupt dropped without a clear");
  a_gain_fall: assert property (|($past(cfr_gain_sel) & ~cfr_gain_sel) |-> $past(alm_wr))
    else $error("gain select dropped without a clear");
  a_gain_irq: assert property (|cfr_gain_sel |-> irq_out_pin)
    else $error("gain select without interrupt");
  a_gain_steady: assert property (!$past(reg_wr) |-> $stable(cfr_gain_value))
    else $error("gain value moved without a write");
  a_irq_status: assert property (alm_rd |=> (reg_rdata[7:0] != 8'h0) == $past(irq_out_pin))
    else $error("interrupt disagrees with status");
  a_gain_status: assert property (alm_rd |=> (reg_rdata[7:4] & $past(cfr_gain_sel)) == $past(cfr_gain_sel))
    else $error("gain select without second alarm bit");
  a_gain_write: assert property (reg_wr && reg_addr == 8'h8c |=> cfr_gain_value[15:0] == $past(wd_lo))
    else $error("gain value not taken from write");
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sync_go = 1'b0;
  // streams 0 and 2 carry different power so a wrong stream pick shows up
  logic [71:0] amp = {18'h0, 18'h20, 18'h0, 18'h40};
  logic [31:0] reg_rdata;
  logic [575:0] node_i, node_q;
  logic [7:0] node_valid;
  logic startup_trigger_in, shared_feedback_trigger_in, event_trigger_out, irq_out_pin;
  logic [3:0] cfr_gain_sel;
  logic [63:0] cfr_gain_value;
  int fail_count = 0;
  int tests_run = 0;
  always #4 clk_sys = ~clk_sys;
  pma_far i_far (.clk_sys, .amp, .sync_go, .node_i, .node_q, .node_valid,
    .startup_trigger_in, .shared_feedback_trigger_in);
  pma_top i_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .node_i, .node_q, .node_valid, .startup_trigger_in, .shared_feedback_trigger_in,
    .event_trigger_out, .irq_out_pin, .cfr_gain_sel, .cfr_gain_value);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rc(8'h08, 32'h58);
    rc(8'h10, 32'h100);
    rc(8'h24, 32'h400);
    rc(8'h2c, 32'hffffffff);
    chk(cfr_gain_value[31:0], 32'h80008000);
    wr(8'h8c, 32'h1234);
    #1 chk({16'h0, cfr_gain_value[15:0]}, 32'h1234);
    $display("reset test done");
  endtask
  task automatic t_meter;
    wr(8'h24, 32'h4);
    wr(8'h28, 32'h0);
    wr(8'h20, 32'h33);
    sync_go <= 1'b1;
    @(posedge clk_sys);
    sync_go <= 1'b0;
    repeat (100) if (!event_trigger_out) @(posedge clk_sys) #1;
    chk({31'h0, event_trigger_out}, 32'h1);
    rc(8'h00, 32'h1);
    rc(8'h30, 32'h200);
    rc(8'h38, 32'h80);
    rc(8'h3c, 32'h4);
    wr(8'h00, 32'h1);
    rc(8'h00, 32'h0);
    $display("interval meter test done");
  endtask
  task automatic t_avg;
    wr(8'h80, 32'h80);
    wr(8'h08, 32'h60808);
    repeat (300) if (!irq_out_pin) @(posedge clk_sys) #1;
    chk({28'h0, cfr_gain_sel}, 32'h1);
    rc(8'h04, 32'h10);
    wr(8'h04, 32'h10);
    #1 chk({28'h0, cfr_gain_sel}, 32'h0);
    chk({31'h0, irq_out_pin}, 32'h0);
    $display("average alarm test done");
  endtask
  task automatic t_peak_low;
    wr(8'h94, 32'h10);
    wr(8'h88, 32'h100);
    wr(8'h14, 32'h3);
    wr(8'h08, 32'h42608);
    repeat (300) if (!irq_out_pin) @(posedge clk_sys) #1;
    repeat (20) @(posedge clk_sys);
    rc(8'hc0, 32'h200);
    rc(8'h04, 32'h3);
    wr(8'h04, 32'h3);
    #1 chk({31'h0, irq_out_pin}, 32'h0);
    $display("peak and low alarm test done");
  endtask
  task automatic t_gate;
    wr(8'h08, 32'h58);
    wr(8'h0c, 32'h8);
    wr(8'h08, 32'h400d8);
    rc(8'hd0, 32'h0);
    @(posedge clk_sys);
    sync_go <= 1'b1;
    @(posedge clk_sys);
    sync_go <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rc(8'hd0, 32'h8);
    wr(8'h08, 32'h610d8);
    rc(8'h04, 32'h10);
    chk({28'h0, cfr_gain_sel}, 32'h0);
    $display("gating test done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_meter;
    t_avg;
    t_peak_low;
    t_gate;
    complete_run;
  end
  initial begin
    #200000;
    fail_count++;
    complete_run;
  end
endmodule
bind pma_top pma_props i_props (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .irq_out_pin, .cfr_gain_sel, .cfr_gain_value);
